// ===== icw_pkg.sv
// Package: constants for the cascaded interrupt command-word block.
// Assumes byte-wide host I/O writes and reads at the documented ports.
`default_nettype none
package icw_pkg;
    // Port addresses (low byte of the I/O address)
    localparam logic [7:0] MASTER_CMD_ADDR  = 8'h20;
    localparam logic [7:0] MASTER_MASK_ADDR = 8'h21;
    localparam logic [7:0] SLAVE_CMD_ADDR   = 8'hA0;
    localparam logic [7:0] SLAVE_MASK_ADDR  = 8'hA1;
    // Even-port word selection bits
    localparam int SEL_INIT_BIT = 4;
    localparam int SEL_OP3_BIT  = 3;
    // Fourth init word fields
    localparam int NEST_BIT = 4;
    localparam int AUTO_BIT = 1;
    // Command word fields
    localparam int FUNC_MSB  = 7;
    localparam int FUNC_LSB  = 5;
    localparam int LEVEL_MSB = 2;
    // Function codes
    localparam logic [2:0] FN_ROT_AUTO_OFF = 3'h0;
    localparam logic [2:0] FN_NONSPEC      = 3'h1;
    localparam logic [2:0] FN_NOP          = 3'h2;
    localparam logic [2:0] FN_SPEC         = 3'h3;
    localparam logic [2:0] FN_ROT_AUTO_ON  = 3'h4;
    localparam logic [2:0] FN_ROT_NONSPEC  = 3'h5;
    localparam logic [2:0] FN_SET_PRIO     = 3'h6;
    localparam logic [2:0] FN_ROT_SPEC     = 3'h7;
    // Reset values
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [2:0] LOWEST_RESET = 3'h7;
    // Slave request feeds this master input
    localparam int CASCADE_INPUT = 2;
    // Init sequence position after first word
    typedef enum logic [1:0] {
        ICW_IDLE, ICW_WAIT2, ICW_WAIT3, ICW_WAIT4
    } icw_init_t;
endpackage
`default_nettype wire

// ===== icw_sync.sv
// Two-flip-flop synchroniser for eight request pins.
// Assumes a single system clock with clock enable.
`default_nettype none
module icw_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] d_i,
    output logic      [7:0] q_o
);
    logic [7:0] meta_reg;

    // First stage read only by second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 8'h00;
            q_o      <= 8'h00;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== icw_ctrl.sv
// One controller: init sequencing, mask, in-service and command words.
// Assumes host strobes are synchronous one-cycle pulses on clk_i.
`default_nettype none
module icw_ctrl (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       cmd_wr_i,
    input  wire logic       mask_wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       is_master_i,
    input  wire logic       ack_i,
    input  wire logic       ack2_end_i,
    input  wire logic [7:0] req_i,
    output logic      [7:0] mask_o,
    output logic      [7:0] in_service_o,
    output logic            int_o,
    output logic      [2:0] ack_level_o,
    output logic            multi_nest_o,
    output logic            auto_eos_o,
    output logic            rot_auto_o,
    output logic      [2:0] lowest_o
);
    icw_pkg::icw_init_t init_reg;
    logic [7:0] irr;
    logic [7:0] eligible;
    logic [2:0] hi_req;
    logic       hi_req_v;
    logic [2:0] hi_svc;
    logic       hi_svc_v;
    logic [2:0] fn;
    logic [2:0] lvl;
    logic       is_init;
    logic       is_op2;

    assign fn      = wdata_i[icw_pkg::FUNC_MSB:icw_pkg::FUNC_LSB];
    assign lvl     = wdata_i[icw_pkg::LEVEL_MSB:0];
    assign is_init = cmd_wr_i & wdata_i[icw_pkg::SEL_INIT_BIT];
    assign is_op2  = cmd_wr_i & ~wdata_i[icw_pkg::SEL_INIT_BIT]
                   & ~wdata_i[icw_pkg::SEL_OP3_BIT];

    // Priority scan from the input after the lowest one
    always_comb begin
        logic [2:0] idx;
        hi_req   = 3'h0;
        hi_req_v = 1'b0;
        hi_svc   = 3'h0;
        hi_svc_v = 1'b0;
        idx      = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            idx = lowest_o + 3'(k + 1);
            if (in_service_o[idx]) begin
                hi_svc   = idx;
                hi_svc_v = 1'b1;
            end
            if (eligible[idx]) begin
                hi_req   = idx;
                hi_req_v = 1'b1;
            end
        end
    end

    // Masked requests; in-service blocks equal or lower priority
    always_comb begin
        irr      = req_i & ~mask_o;
        eligible = irr & ~in_service_o;
        // Nested requests on the cascade input pass when nesting enabled
        if (multi_nest_o && is_master_i) begin
            eligible[icw_pkg::CASCADE_INPUT] = irr[icw_pkg::CASCADE_INPUT];
        end
        if (hi_svc_v) begin
            for (int k = 0; k < 8; k++) begin
                if (3'(k) - lowest_o - 3'h1 >= hi_svc - lowest_o - 3'h1 &&
                    !(multi_nest_o && is_master_i &&
                      k == icw_pkg::CASCADE_INPUT &&
                      hi_svc == 3'(icw_pkg::CASCADE_INPUT))) begin
                    eligible[k] = 1'b0;
                end
            end
        end
    end

    // Initialization sequence tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_reg <= icw_pkg::ICW_IDLE;
        end else if (ce_i) begin
            if (is_init) begin
                init_reg <= icw_pkg::ICW_WAIT2;
            end else if (mask_wr_i) begin
                case (init_reg)
                    icw_pkg::ICW_WAIT2: init_reg <= icw_pkg::ICW_WAIT3;
                    icw_pkg::ICW_WAIT3: init_reg <= icw_pkg::ICW_WAIT4;
                    icw_pkg::ICW_WAIT4: init_reg <= icw_pkg::ICW_IDLE;
                    default:            init_reg <= icw_pkg::ICW_IDLE;
                endcase
            end else if (cmd_wr_i) begin
                init_reg <= icw_pkg::ICW_IDLE;
            end
        end
    end

    // Fourth init word: only nesting and auto bits kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multi_nest_o <= 1'b0;
            auto_eos_o   <= 1'b0;
        end else if (ce_i && mask_wr_i &&
                     init_reg == icw_pkg::ICW_WAIT4) begin
            multi_nest_o <= wdata_i[icw_pkg::NEST_BIT];
            auto_eos_o   <= wdata_i[icw_pkg::AUTO_BIT];
        end
    end

    // Mask word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_o <= icw_pkg::MASK_RESET;
        end else if (ce_i) begin
            if (is_init) begin
                mask_o <= icw_pkg::MASK_RESET;
            end else if (mask_wr_i && init_reg == icw_pkg::ICW_IDLE) begin
                mask_o <= wdata_i;
            end
        end
    end

    // In-service bits and rotation state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_service_o <= 8'h00;
            rot_auto_o   <= 1'b0;
            lowest_o     <= icw_pkg::LOWEST_RESET;
            ack_level_o  <= 3'h0;
        end else if (ce_i) begin
            if (is_init) begin
                in_service_o <= 8'h00;
                rot_auto_o   <= 1'b0;
                lowest_o     <= icw_pkg::LOWEST_RESET;
            end else if (ack_i && hi_req_v) begin
                in_service_o[hi_req] <= 1'b1;
                ack_level_o          <= hi_req;
            end else if (ack2_end_i && auto_eos_o && hi_svc_v) begin
                in_service_o[hi_svc] <= 1'b0;
                if (rot_auto_o) begin
                    lowest_o <= hi_svc;
                end
            end else if (is_op2) begin
                case (fn)
                    icw_pkg::FN_ROT_AUTO_OFF: rot_auto_o <= 1'b0;
                    icw_pkg::FN_ROT_AUTO_ON:  rot_auto_o <= 1'b1;
                    icw_pkg::FN_NONSPEC: begin
                        if (hi_svc_v) begin
                            in_service_o[hi_svc] <= 1'b0;
                        end
                    end
                    icw_pkg::FN_ROT_NONSPEC: begin
                        if (hi_svc_v) begin
                            in_service_o[hi_svc] <= 1'b0;
                            lowest_o             <= hi_svc;
                        end
                    end
                    icw_pkg::FN_SPEC: begin
                        in_service_o[lvl] <= 1'b0;
                    end
                    icw_pkg::FN_SET_PRIO: begin
                        lowest_o <= lvl;
                    end
                    icw_pkg::FN_ROT_SPEC: begin
                        in_service_o[lvl] <= 1'b0;
                        lowest_o          <= lvl;
                    end
                    default: ;  // No operation
                endcase
            end
        end
    end

    // Request output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_o <= 1'b0;
        end else if (ce_i) begin
            int_o <= hi_req_v & (init_reg == icw_pkg::ICW_IDLE);
        end
    end
endmodule
`default_nettype wire

// ===== icw_top.sv
// File holds the master/slave pair and the host port decode.
// Assumes host strobes synchronous to clk_i, request pins asynchronous.
`default_nettype none
module icw_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        ack_i,
    input  wire logic        ack2_end_i,
    input  wire logic [15:0] request_input_i,
    output logic      [7:0]  rdata_o,
    output logic             int_o,
    output logic      [7:0]  master_in_service_o,
    output logic      [7:0]  slave_in_service_o
);
    logic [15:0] req_sync;
    logic [7:0]  m_req;
    logic [7:0]  m_mask;
    logic [7:0]  s_mask;
    logic [7:0]  m_svc;
    logic [7:0]  s_svc;
    logic        m_int;
    logic        s_int;
    logic        s_ack;
    logic        s_ack2;

    // Request pins through two flip-flops
    icw_sync u_sync_m (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (request_input_i[7:0]),
        .q_o   (req_sync[7:0])
    );
    icw_sync u_sync_s (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (request_input_i[15:8]),
        .q_o   (req_sync[15:8])
    );

    // Slave request replaces master input 2
    always_comb begin
        m_req = req_sync[7:0];
        m_req[icw_pkg::CASCADE_INPUT] = s_int;
    end

    // Acknowledge goes to slave whenever the slave request output is high
    assign s_ack  = ack_i & m_int & ~s_int ? 1'b0 : ack_i & s_int;
    assign s_ack2 = ack2_end_i & (s_svc != 8'h00);

    icw_ctrl u_master (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .cmd_wr_i     (wr_i && addr_i == icw_pkg::MASTER_CMD_ADDR),
        .mask_wr_i    (wr_i && addr_i == icw_pkg::MASTER_MASK_ADDR),
        .wdata_i      (wdata_i),
        .is_master_i  (1'b1),
        .ack_i        (ack_i),
        .ack2_end_i   (ack2_end_i),
        .req_i        (m_req),
        .mask_o       (m_mask),
        .in_service_o (m_svc),
        .int_o        (m_int),
        .ack_level_o  (),
        .multi_nest_o (),
        .auto_eos_o   (),
        .rot_auto_o   (),
        .lowest_o     ()
    );

    icw_ctrl u_slave (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .cmd_wr_i     (wr_i && addr_i == icw_pkg::SLAVE_CMD_ADDR),
        .mask_wr_i    (wr_i && addr_i == icw_pkg::SLAVE_MASK_ADDR),
        .wdata_i      (wdata_i),
        .is_master_i  (1'b0),
        .ack_i        (s_ack),
        .ack2_end_i   (s_ack2),
        .req_i        (req_sync[15:8]),
        .mask_o       (s_mask),
        .in_service_o (s_svc),
        .int_o        (s_int),
        .ack_level_o  (),
        .multi_nest_o (),
        .auto_eos_o   (),
        .rot_auto_o   (),
        .lowest_o     ()
    );

    // Registered read data and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o             <= 8'h00;
            int_o               <= 1'b0;
            master_in_service_o <= 8'h00;
            slave_in_service_o  <= 8'h00;
        end else if (ce_i) begin
            int_o               <= m_int;
            master_in_service_o <= m_svc;
            slave_in_service_o  <= s_svc;
            if (rd_i) begin
                case (addr_i)
                    icw_pkg::MASTER_MASK_ADDR: rdata_o <= m_mask;
                    icw_pkg::SLAVE_MASK_ADDR:  rdata_o <= s_mask;
                    default:                   rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== icw_chk_sva.sv
// Checker: port-level assertions for the command-word block.
// Assumes no command while ce_i is low; bound into icw_top below.
`default_nettype none
module icw_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        ack_i,
    input wire logic        ack2_end_i,
    input wire logic [15:0] request_input_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        int_o,
    input wire logic [7:0]  master_in_service_o,
    input wire logic [7:0]  slave_in_service_o
);
    logic [1:0] cnt_q [2];
    logic [7:0] msk_q [2];
    logic       cmd_w;
    logic       cmd_m;
    logic       cmd_s;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Command-word write with no first acknowledge in the same cycle
    assign cmd_w = ce_i && wr_i && !wdata_i[4] && !wdata_i[3] && !ack_i;
    assign cmd_m = cmd_w && addr_i == 8'h20;
    assign cmd_s = cmd_w && addr_i == 8'hA0;
    // Shadow of init position and mask for each controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '{default: 2'h0};
            msk_q <= '{default: 8'h00};
        end else if (ce_i && wr_i && addr_i[6:0] == 7'h20 && wdata_i[4]) begin
            cnt_q[addr_i[7]] <= 2'h3;
            msk_q[addr_i[7]] <= 8'h00;
        end else if (ce_i && wr_i && addr_i[6:0] == 7'h21) begin
            if (cnt_q[addr_i[7]] != 2'h0)
                cnt_q[addr_i[7]] <= cnt_q[addr_i[7]] - 2'h1;
            else
                msk_q[addr_i[7]] <= wdata_i;
        end
    end
    mask_read_a: assert property (rd_i && ce_i && !wr_i && addr_i[6:0] == 7'h21
        |=> rdata_o == msk_q[$past(addr_i[7])]) else $error("mask readback");
    unmapped_read_a: assert property (rd_i && ce_i && addr_i[6:0] != 7'h21
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!(rd_i && ce_i) |=> $stable(rdata_o))
        else $error("read data moved");
    eos_high_a: assert property (cmd_m && wdata_i[6:5] == 2'b01 |-> ##2
        ($onehot0(master_in_service_o ^ $past(master_in_service_o, 2))
        && (master_in_service_o & ~$past(master_in_service_o, 2)) == 8'h00
        && ($past(master_in_service_o, 2) == 8'h00
        || master_in_service_o != $past(master_in_service_o, 2))))
        else $error("nonspecific end wrong");
    eos_named_a: assert property (cmd_m && wdata_i[6:5] == 2'b11 |-> ##2
        master_in_service_o == ($past(master_in_service_o, 2)
        & ~(8'h01 << $past(wdata_i[2:0], 2)))) else $error("named end wrong");
    slave_named_a: assert property (cmd_s && wdata_i[6:5] == 2'b11 |-> ##2
        slave_in_service_o == ($past(slave_in_service_o, 2)
        & ~(8'h01 << $past(wdata_i[2:0], 2)))) else $error("slave end wrong");
    eos_none_a: assert property (cmd_m && !wdata_i[5] |-> ##2
        master_in_service_o == $past(master_in_service_o, 2))
        else $error("service changed by non-end code");
    mask_all_a: assert property ((msk_q[0] == 8'hFF) [*5] |-> !int_o)
        else $error("request passed full mask");
    // Main scenarios reached
    cover property (cmd_m && wdata_i[7:5] == icw_pkg::FN_NONSPEC);
    cover property ($rose(int_o));
    cover property (slave_in_service_o != 8'h00 && ack_i);
endmodule
bind icw_top icw_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .ack_i(ack_i), .ack2_end_i(ack2_end_i),
    .request_input_i(request_input_i), .rdata_o(rdata_o), .int_o(int_o),
    .master_in_service_o(master_in_service_o),
    .slave_in_service_o(slave_in_service_o));
`default_nettype wire

// ===== icw_host.sv
// Host model: byte I/O cycles, command words and acknowledges.
// Assumes the block takes strobes on the rising clk_i edge.
`default_nettype none
module icw_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic       ack_o,
    output var  logic       ack2_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o, ack_o, ack2_o} = '0;
    end
    // Write cycle; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask
    // Read cycle; data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {addr_o, rd_o} = {a, 1'b1};
        @(negedge clk_i);
        {addr_o, rd_o} = {~a, 1'b0};
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // Command word with selector bits kept zero
    task automatic cmd(input logic [7:0] a, input logic [2:0] f,
                       input logic [2:0] l);
        wr(a, {f, 2'b00, l});
    endtask
    // First acknowledge pulse, then trailing edge of the second
    task automatic ack1();
        @(negedge clk_i);
        ack_o = 1'b1;
        @(negedge clk_i);
        ack_o = 1'b0;
    endtask
    task automatic ack2();
        @(negedge clk_i);
        ack2_o = 1'b1;
        @(negedge clk_i);
        ack2_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== interrupt_command_words_bench.sv
// Bench: host model and request pins around the command-word block.
// Assumes icw_top, icw_host and the bound checker are compiled first.
`default_nettype none
module interrupt_command_words_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce  = 1'b1;
    logic [15:0] req = 16'h0000;
    logic [7:0]  addr, wdata, rdata, svc_m, svc_s, d;
    logic        wr, rd, ack, ack2, irq;
    int          n_errors = 0;
    int          checked = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    icw_host i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .ack_o(ack), .ack2_o(ack2));
    icw_top i_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .ack_i(ack),
        .ack2_end_i(ack2), .request_input_i(req), .rdata_o(rdata),
        .int_o(irq), .master_in_service_o(svc_m),
        .slave_in_service_o(svc_s));
    task automatic close_out();
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the request output, then check it and end the run on timeout
    task automatic wait_irq();
        for (int i = 0; i < 12 && irq !== 1'b1; i++) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        if (irq !== 1'b1) close_out();
    endtask
    task automatic init(input logic [7:0] b, input logic [7:0] w4);
        i_host.wr(b, 8'h11);
        i_host.wr(b + 8'h01, 8'h08);
        i_host.wr(b + 8'h01, b[7] ? 8'h02 : 8'h04);
        i_host.wr(b + 8'h01, w4);
    endtask
    task automatic cmd(input logic [7:0] b, input logic [2:0] f,
                       input logic [2:0] l, input logic [7:0] exp);
        i_host.cmd(b, f, l);
        repeat (3) @(negedge clk);
        chk(b[7] ? svc_s : svc_m, exp);
    endtask
    // Raise pins, acknowledge, check in-service
    task automatic take(input logic [15:0] r, input logic [7:0] exp);
        req = req | r;
        wait_irq();
        i_host.ack1();
        i_host.ack2();
        repeat (2) @(negedge clk);
        chk(svc_m, exp);
    endtask
    // Mask access and clearing by the first init word
    task automatic t_mask();
        init(8'h20, 8'hFD);
        init(8'hA0, 8'h01);
        i_host.wr(8'h21, 8'hFF);
        req = 16'h00FF;
        i_host.wr(8'hA1, 8'hC3);
        i_host.rd(8'h21, d);
        chk(d, 8'hFF);
        i_host.rd(8'hA1, d);
        chk(d, 8'hC3);
        i_host.rd(8'h22, d);
        chk(d, 8'h00);
        chk({7'h00, irq}, 8'h00);
        req = 16'h0000;
        init(8'hA0, 8'h01);
        i_host.rd(8'hA1, d);
        chk(d, 8'h00);
        i_host.wr(8'h21, 8'h00);
    endtask
    // Every command code on the master
    task automatic t_eoi();
        take(16'h0020, 8'h20);
        take(16'h0008, 8'h28);
        take(16'h0001, 8'h29);
        req = 16'h0000;
        cmd(8'h20, icw_pkg::FN_NONSPEC, 3'h6, 8'h28);
        cmd(8'h20, icw_pkg::FN_NOP, 3'h3, 8'h28);
        cmd(8'h20, icw_pkg::FN_ROT_AUTO_ON, 3'h3, 8'h28);
        cmd(8'h20, icw_pkg::FN_ROT_AUTO_OFF, 3'h3, 8'h28);
        cmd(8'h20, icw_pkg::FN_SPEC, 3'h5, 8'h08);
        cmd(8'h20, icw_pkg::FN_ROT_SPEC, 3'h3, 8'h00);
        cmd(8'h20, icw_pkg::FN_NONSPEC, 3'h0, 8'h00);
        take(16'h0002, 8'h02);
        req = 16'h0000;
        cmd(8'h20, icw_pkg::FN_ROT_NONSPEC, 3'h0, 8'h00);
        take(16'h0009, 8'h08);
        cmd(8'h20, icw_pkg::FN_SET_PRIO, 3'h3, 8'h08);
        take(16'h0000, 8'h09);
        req = 16'h0000;
        cmd(8'h20, icw_pkg::FN_SPEC, 3'h0, 8'h08);
        cmd(8'h20, icw_pkg::FN_SPEC, 3'h3, 8'h00);
        take(16'h0041, 8'h40);
        cmd(8'h20, icw_pkg::FN_SET_PRIO, 3'h7, 8'h40);
        take(16'h0000, 8'h41);
        req = 16'h0000;
        cmd(8'h20, icw_pkg::FN_SPEC, 3'h0, 8'h40);
        cmd(8'h20, icw_pkg::FN_SPEC, 3'h6, 8'h00);
    endtask
    // Slave nesting through master input 2, then ordered exit
    task automatic t_nest();
        take(16'h1000, 8'h04);
        chk(svc_s, 8'h10);
        req = 16'h0000;
        take(16'h0200, 8'h04);
        chk(svc_s, 8'h12);
        req = 16'h0000;
        cmd(8'hA0, icw_pkg::FN_NONSPEC, 3'h0, 8'h10);
        cmd(8'hA0, icw_pkg::FN_SPEC, 3'h6, 8'h10);
        cmd(8'hA0, icw_pkg::FN_NONSPEC, 3'h0, 8'h00);
        cmd(8'h20, icw_pkg::FN_NONSPEC, 3'h0, 8'h00);
    endtask
    // Automatic end on the trailing edge of the second acknowledge
    task automatic t_auto();
        init(8'h20, 8'h12);
        req = 16'h0002;
        wait_irq();
        i_host.ack1();
        repeat (2) @(negedge clk);
        chk(svc_m, 8'h02);
        req = 16'h0000;
        i_host.ack2();
        repeat (2) @(negedge clk);
        chk(svc_m, 8'h00);
    endtask
    // One masked input leaves input 6 served
    task automatic t_block();
        i_host.wr(8'h21, 8'h08);
        req = 16'h0008;
        repeat (8) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        i_host.ack1();
        i_host.ack2();
        take(16'h0040, 8'h00);
    endtask
    // Clock enable low freezes state: the mask write is dropped
    task automatic t_hold();
        ce = 1'b0;
        i_host.wr(8'h21, 8'h55);
        ce = 1'b1;
        i_host.rd(8'h21, d);
        chk(d, 8'h08);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_mask();
        t_eoi();
        t_nest();
        t_auto();
        t_block();
        t_hold();
        close_out();
    end
endmodule
`default_nettype wire
